// ==== design/access_timer.v ====
// state sequencer for one external or on-chip access
// assumes start is only honoured while idle; length is 2 to 6 states
`timescale 1ns/1ns
`default_nettype none

module access_timer (
  input  wire       aclk,        // system clock
  input  wire       aresetn,     // synchronous reset, active low
  input  wire       start,       // begin an access
  input  wire [2:0] total,       // access length in states
  output reg        busy_reg,    // an access state is in progress
  output reg        wait_reg,    // current state is a program wait
  output reg        final_reg,   // current state transfers data
  output reg  [2:0] index_reg    // number of the current state, 1 based
);

  reg [2:0] total_reg;
  reg [2:0] index_next;
  reg [2:0] total_next;

  always @* begin
    total_next = total_reg;
    index_next = 3'h0;
    if (!busy_reg && start) begin
      total_next = total;
      index_next = 3'h1;
    end else if (busy_reg && index_reg != total_reg) begin
      index_next = index_reg + 3'h1;
    end
  end

  // ==========================================================
  // state flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      total_reg <= 3'h0;
      index_reg <= 3'h0;
      busy_reg  <= 1'b0;
      wait_reg  <= 1'b0;
      final_reg <= 1'b0;
    end else begin
      total_reg <= total_next;
      index_reg <= index_next;
      busy_reg  <= (index_next != 3'h0);
      wait_reg  <= (index_next >= 3'h3) && (index_next < total_next);
      final_reg <= (index_next != 3'h0) && (index_next == total_next);
    end
  end

endmodule // access_timer

`default_nettype wire

// ==== design/area_bus_regs.vh ====
// register indices, field layout, reset values and access timing counts
// assumes the byte address of a register is four times its index
`ifndef AREA_BUS_REGS_VH
`define AREA_BUS_REGS_VH

// register indices (byte address = index * 4)
`define IDX_AREA_BUS_WIDTH        8'h20
`define IDX_AREA_ACCESS_STATES    8'h21
`define IDX_UPPER_AREA_WAIT_COUNT 8'h22
`define IDX_LOWER_AREA_WAIT_COUNT 8'h23
`define IDX_BUS_STATUS            8'h24

// reset values
`define RST_WIDTH_NARROW 8'hFF
`define RST_WIDTH_WIDE   8'h00
`define RST_STATES       8'hFF
`define RST_WAIT         8'hFF

// wait field of area n sits at bits [2*(n%4)+1 : 2*(n%4)]
`define WAIT_FIELD_W 2

// access lengths in states
`define STATES_TWO    3'h2
`define STATES_THREE  3'h3
`define STATES_ONCHIP 3'h2
`define STATES_DRAM   3'h3

// status register fields
`define ST_BUS8_BIT  0
`define ST_BUSY_BIT  1
`define ST_MODE_LSB  4

// AXI responses
`define RESP_OKAY   2'h0
`define RESP_DECERR 2'h3

`endif

// ==== design/external_area_bus_config.v ====
// external area bus configuration registers and access length decision
// assumes an AXI4-Lite master with one write and one read outstanding,
// mode pins stable around reset and an access requester that waits on busy
//
// Notes on behaviour
// - all width bits one gives 8-bit bus
// - any width bit zero gives 16-bit bus
// - width resets by mode, kept in software standby
// - width bit n: 0 wide, 1 narrow
// - on-chip and single-chip ignore width bits
// - state bit n: 0 two, 1 three states
// - state register resets to all ones
// - on-chip and single-chip ignore state bits
// - DRAM areas ignore their state bit
// - two-state areas get no program waits
// - both wait registers reset to ones
// - upper wait fields: areas 7 to 4
// - wait field adds zero to three states
// - on-chip ignores wait fields
// - lower wait fields: areas 3 to 0
`timescale 1ns/1ns
`default_nettype none
`include "area_bus_regs.vh"

module external_area_bus_config (
  input  wire        aclk,             // system clock, 25 MHz
  input  wire        aresetn,          // synchronous reset, active low
  input  wire        hw_standby,       // hardware standby, high re-initialises
  input  wire        sw_standby,       // software standby, contents kept
  input  wire [2:0]  mode_pins,        // operating mode 1 to 7
  input  wire [7:0]  dram_area_mask,   // areas set as DRAM space
  // access request
  input  wire        acc_start,        // start an access, taken while idle
  input  wire [2:0]  acc_area,         // area of the access
  input  wire        acc_onchip,       // access targets on-chip memory
  output reg         acc_wide_reg,     // access uses 16-bit data
  output wire        acc_busy,         // access in progress
  output wire        acc_wait,         // program wait state
  output wire        acc_final,        // data transfer state
  output wire [2:0]  acc_index,        // current state number
  output reg         bus_8bit_reg,     // whole bus runs 8-bit
  output reg         port4_gpio_reg,   // lower data lines free as port
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,     // write address
  input  wire        s_axi_awvalid,    // write address valid
  output reg         s_axi_awready,    // write address ready
  input  wire [31:0] s_axi_wdata,      // write data
  input  wire [3:0]  s_axi_wstrb,      // write byte strobes
  input  wire        s_axi_wvalid,     // write data valid
  output reg         s_axi_wready,     // write data ready
  output reg  [1:0]  s_axi_bresp,      // write response
  output reg         s_axi_bvalid,     // write response valid
  input  wire        s_axi_bready,     // write response ready
  input  wire [11:0] s_axi_araddr,     // read address
  input  wire        s_axi_arvalid,    // read address valid
  output reg         s_axi_arready,    // read address ready
  output reg  [31:0] s_axi_rdata,      // read data
  output reg  [1:0]  s_axi_rresp,      // read response
  output reg         s_axi_rvalid,     // read data valid
  input  wire        s_axi_rready      // read data ready
);

  // ==========================================================
  // decode helpers
  function [7:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  function mapped;
    input [7:0] idx;
    begin
      mapped = (idx >= `IDX_AREA_BUS_WIDTH) && (idx <= `IDX_BUS_STATUS);
    end
  endfunction

  function single_chip;
    input [2:0] m;
    begin
      single_chip = (m == 3'h6) || (m == 3'h7);
    end
  endfunction

  // one-hot select of the four writable registers, shared by write and read
  function [3:0] cfg_select;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_AREA_BUS_WIDTH:        cfg_select = 4'h1;
        `IDX_AREA_ACCESS_STATES:    cfg_select = 4'h2;
        `IDX_UPPER_AREA_WAIT_COUNT: cfg_select = 4'h4;
        `IDX_LOWER_AREA_WAIT_COUNT: cfg_select = 4'h8;
        default:                    cfg_select = 4'h0;
      endcase
    end
  endfunction

  // ==========================================================
  // configuration registers
  reg  [7:0] area_bus_width_reg;
  reg  [7:0] area_access_states_reg;
  reg  [7:0] upper_area_wait_count_reg;
  reg  [7:0] lower_area_wait_count_reg;
  reg  [2:0] mode_reg;

  reg        aw_held_reg;
  reg  [7:0] aw_index_reg;
  reg        w_held_reg;
  reg  [7:0] w_data_reg;
  reg        w_strb_reg;

  wire       do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire       wr_ok    = do_write && w_strb_reg;
  wire [3:0] wr_sel   = cfg_select(aw_index_reg);
  wire       init     = !aresetn || hw_standby;

  wire [7:0] width_init = (mode_pins == 3'h2 || mode_pins == 3'h4) ?
                          `RST_WIDTH_WIDE : `RST_WIDTH_NARROW;

  // mode is sampled while reset is held, so it settles with the defaults
  always @(posedge aclk) begin
    if (init) begin
      mode_reg <= mode_pins;
    end
  end

  // software standby has no term here: values simply stay
  always @(posedge aclk) begin
    if (init) begin
      area_bus_width_reg        <= width_init;
      area_access_states_reg    <= `RST_STATES;
      upper_area_wait_count_reg <= `RST_WAIT;
      lower_area_wait_count_reg <= `RST_WAIT;
    end else if (wr_ok) begin
      if (wr_sel[0]) begin
        area_bus_width_reg        <= w_data_reg;
      end
      if (wr_sel[1]) begin
        area_access_states_reg    <= w_data_reg;
      end
      if (wr_sel[2]) begin
        upper_area_wait_count_reg <= w_data_reg;
      end
      if (wr_sel[3]) begin
        lower_area_wait_count_reg <= w_data_reg;
      end
    end
  end

  // ==========================================================
  // per-area wait fields
  wire [1:0] area_wait [0:7];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_wait
      // lower register areas 3 to 0
      assign area_wait[g]     = lower_area_wait_count_reg[2*g+1:2*g];
      // upper register areas 7 to 4
      assign area_wait[g + 4] = upper_area_wait_count_reg[2*g+1:2*g];
    end
  endgenerate

  // ==========================================================
  // access length and width decision
  wire       internal_acc = acc_onchip || single_chip(mode_reg);
  wire       area_narrow  = area_bus_width_reg[acc_area];
  wire       area_three   = area_access_states_reg[acc_area];
  wire       area_dram    = dram_area_mask[acc_area];
  reg  [2:0] acc_total;

  always @* begin
    if (internal_acc) begin
      acc_total = `STATES_ONCHIP;
    end else if (area_dram) begin
      acc_total = `STATES_DRAM;
    end else if (!area_three) begin
      acc_total = `STATES_TWO;
    end else begin
      acc_total = `STATES_THREE + {1'b0, area_wait[acc_area]};
    end
  end

  access_timer u_timer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (acc_start),
    .total     (acc_total),
    .busy_reg  (acc_busy),
    .wait_reg  (acc_wait),
    .final_reg (acc_final),
    .index_reg (acc_index)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_wide_reg <= 1'b0;
    end else if (acc_start && !acc_busy) begin
      acc_wide_reg <= internal_acc || !area_narrow;
    end
  end

  // ==========================================================
  // bus mode
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_8bit_reg   <= 1'b0;
      port4_gpio_reg <= 1'b0;
    end else begin
      bus_8bit_reg   <= (area_bus_width_reg == `RST_WIDTH_NARROW);
      port4_gpio_reg <= (area_bus_width_reg == `RST_WIDTH_NARROW);
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      aw_index_reg  <= 8'h00;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 8'h00;
      w_strb_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        aw_index_reg  <= reg_index(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata[7:0];
        w_strb_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_index_reg) ? `RESP_OKAY : `RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  reg  [7:0] rd_value;
  wire [3:0] rd_sel = cfg_select(reg_index(s_axi_araddr));

  always @* begin
    rd_value = 8'h00;
    case (rd_sel)
      4'h1:    rd_value = area_bus_width_reg;
      4'h2:    rd_value = area_access_states_reg;
      4'h4:    rd_value = upper_area_wait_count_reg;
      4'h8:    rd_value = lower_area_wait_count_reg;
      default: rd_value = 8'h00;
    endcase
    // status is read-only, so it stays outside the writable select
    if (reg_index(s_axi_araddr) == `IDX_BUS_STATUS) begin
      rd_value[`ST_BUS8_BIT]                 = bus_8bit_reg;
      rd_value[`ST_BUSY_BIT]                 = acc_busy;
      rd_value[`ST_MODE_LSB+2:`ST_MODE_LSB]  = mode_reg;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_value};
        s_axi_rresp   <= mapped(reg_index(s_axi_araddr)) ? `RESP_OKAY : `RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // sw_standby is accepted for completeness; nothing is cleared by it
  wire unused_ok = sw_standby;

endmodule // external_area_bus_config

`default_nettype wire

// ==== tb/cfg_props.sv ====
// checker: access sequencing and width outputs
// assumes a bind onto the bus config top
`timescale 1ns/1ns
`default_nettype none
module cfg_props (
  input wire logic       aclk,           // clock
  input wire logic       aresetn,        // reset
  input wire logic [2:0] mode_pins,      // mode
  input wire logic [7:0] dram_area_mask, // dram
  input wire logic       acc_start,      // start
  input wire logic [2:0] acc_area,       // area
  input wire logic       acc_onchip,     // on-chip
  input wire logic       acc_wide_reg,   // 16-bit
  input wire logic       acc_busy,       // busy
  input wire logic       acc_wait,       // wait
  input wire logic       acc_final,      // data
  input wire logic [2:0] acc_index,      // state
  input wire logic       bus_8bit_reg,   // 8-bit
  input wire logic       port4_gpio_reg  // port
);
  // ==========
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // single-chip modes act like on-chip
  wire ext = !acc_onchip && mode_pins < 3'h6;
  sequence s_take; acc_start && !acc_busy; endsequence
  sequence s_ext; s_take ##0 ext; endsequence
  chk_take_first: assert property (s_take |=> acc_busy && acc_index == 3'h1)
    else $error("access did not open at state one");
  chk_wait_order: assert property (acc_wait |=> acc_wait || acc_final)
    else $error("wait not followed by wait or data");
  chk_final_ends: assert property (acc_final |=> !acc_busy)
    else $error("access ran past its data state");
  chk_early_nowait: assert property (acc_busy && acc_index < 3'h3 |-> !acc_wait)
    else $error("wait in first two states");
  chk_onchip_len: assert property (s_take ##0 acc_onchip |=> !acc_final ##1 acc_final)
    else $error("on-chip access not two states");
  chk_onchip_wide: assert property (s_take ##0 acc_onchip |=> acc_wide_reg)
    else $error("on-chip access not 16-bit");
  chk_dram_len: assert property (s_ext ##0 dram_area_mask[acc_area] |=> !acc_final [*2] ##1 acc_final)
    else $error("dram access not three states");
  chk_narrow_all: assert property (s_ext ##0 bus_8bit_reg |=> !acc_wide_reg)
    else $error("wide access in 8-bit bus mode");
  chk_port_free: assert property (port4_gpio_reg == bus_8bit_reg)
    else $error("port release differs from bus mode");
  chk_index_step: assert property (acc_busy && !acc_final |=> acc_index == $past(acc_index) + 3'h1)
    else $error("state number did not advance by one");
  chk_single_wide: assert property (s_take ##0 mode_pins >= 3'h6 |=> acc_wide_reg)
    else $error("single-chip access not 16-bit");
endmodule // cfg_props
bind external_area_bus_config cfg_props u_cfg_props (.aclk, .aresetn, .mode_pins, .dram_area_mask, .acc_start,
  .acc_area, .acc_onchip, .acc_wide_reg, .acc_busy, .acc_wait, .acc_final, .acc_index, .bus_8bit_reg, .port4_gpio_reg);
`default_nettype wire

// ==== tb/ext_mem_model.sv ====
// far-side memory: times each access in states
// assumes the state outputs of the bus config block
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
  input  wire logic       aclk,      // clock
  input  wire logic       acc_busy,  // access on
  input  wire logic       acc_wait,  // wait state
  input  wire logic       acc_final, // data state
  output var  logic [2:0] len,       // last length
  output var  logic [2:0] waits      // last waits
);
  logic [2:0] cnt = 3'h0;
  logic [2:0] wc = 3'h0;
  // ==========
  // state count
  // data taken last
  always @(posedge aclk) begin
    if (acc_busy) begin
      cnt <= acc_final ? 3'h0 : cnt + 3'h1;
      wc <= acc_final ? 3'h0 : wc + {2'h0, acc_wait};
      if (acc_final) begin
        len <= cnt + 3'h1;
        waits <= wc;
      end
    end
  end
endmodule // ext_mem_model
`default_nettype wire

// ==== tb/external_area_bus_config_tb.sv ====
// bench for the area bus config block
// assumes the block, its checker and the memory model
`timescale 1ns/1ns
`default_nettype none
module external_area_bus_config_tb;
  // ==========
  // signals
  logic        aclk = 1'b0, aresetn = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0;
  logic [2:0]  mode_pins = 3'h1, acc_area = 3'h0;
  logic [7:0]  dram_area_mask = 8'h00;
  logic        acc_start = 1'b0, acc_onchip = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, rdv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  rsp;
  wire         acc_wide_reg, acc_busy, acc_wait, acc_final, bus_8bit_reg, port4_gpio_reg;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [2:0]   acc_index, len, waits;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          err_count = 0, checks_done = 0, cyc = 0;
  external_area_bus_config u_external_area_bus_config (.aclk, .aresetn, .hw_standby, .sw_standby, .mode_pins,
    .dram_area_mask, .acc_start, .acc_area, .acc_onchip, .acc_wide_reg, .acc_busy, .acc_wait, .acc_final,
    .acc_index, .bus_8bit_reg, .port4_gpio_reg, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ext_mem_model u_ext_mem_model (.aclk, .acc_busy, .acc_wait, .acc_final, .len, .waits);
  initial forever #20 aclk = ~aclk;
  // ==========
  // shared tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, 0);
  endtask
  task rd(input [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rc(input [11:0] a, input [7:0] e);
    rd(a);
    chk("rdata", rdv, {24'h0, e});
  endtask
  // starts one access, then judges width, length and waits
  task acc(input [2:0] ar, input oc, input [2:0] el, input [2:0] ew, input wd);
    @(posedge aclk);
    acc_area <= ar;
    acc_onchip <= oc;
    acc_start <= 1'b1;
    @(posedge aclk);
    acc_start <= 1'b0;
    #1 chk("acc_wide", acc_wide_reg, wd);
    do @(posedge aclk); while (acc_busy !== 1'b0);
    #1 chk("length", len, el);
    chk("waits", waits, ew);
  endtask
  task hw(input [2:0] m);
    @(posedge aclk);
    mode_pins <= m;
    hw_standby <= 1'b1;
    repeat (2) @(posedge aclk);
    hw_standby <= 1'b0;
  endtask
  // ==========
  // scenarios
  task t_reset;
    rc(12'h080, 8'hFF);
    rc(12'h084, 8'hFF);
    rc(12'h088, 8'hFF);
    rc(12'h08C, 8'hFF);
    chk("bus_8bit", bus_8bit_reg, 1);
    chk("port4_gpio", port4_gpio_reg, 1);
    acc(3'h6, 1'b0, 3'h6, 3'h3, 1'b0);
    rd(12'h0FC);
    chk("rresp", rsp, 3);
    chk("rdata_unmapped", rdv, 0);
    $display("t_reset done");
  endtask
  task t_width;
    wr(12'h080, 8'hFE);
    @(posedge aclk);
    #1 chk("bus_8bit", bus_8bit_reg, 0);
    acc(3'h0, 1'b0, 3'h6, 3'h3, 1'b1);
    acc(3'h1, 1'b0, 3'h6, 3'h3, 1'b0);
    $display("t_width done");
  endtask
  task t_waits;
    logic [2:0] w;
    wr(12'h088, 8'hE4);
    wr(12'h08C, 8'h1B);
    for (int a = 0; a < 8; a++) begin
      w = 3'(((a < 4 ? 8'h1B : 8'hE4) >> (2 * (a % 4))) & 8'h03);
      acc(3'(a), 1'b0, 3'h3 + w, w, a == 0);
    end
    $display("t_waits done");
  endtask
  task t_special;
    wr(12'h084, 8'hDF);
    acc(3'h5, 1'b0, 3'h2, 3'h0, 1'b0);
    wr(12'h084, 8'hFF);
    dram_area_mask <= 8'h04;
    acc(3'h2, 1'b0, 3'h3, 3'h0, 1'b0);
    acc(3'h7, 1'b1, 3'h2, 3'h0, 1'b1);
    $display("t_special done");
  endtask
  task t_standby;
    @(posedge aclk);
    sw_standby <= 1'b1;
    rc(12'h088, 8'hE4);
    sw_standby <= 1'b0;
    hw(3'h2);
    rc(12'h080, 8'h00);
    rc(12'h08C, 8'hFF);
    hw(3'h6);
    // states and waits left long, so an external timing would show
    wr(12'h084, 8'hFF);
    acc(3'h1, 1'b0, 3'h2, 3'h0, 1'b1);
    rc(12'h090, 8'h61);
    $display("t_standby done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // main sequence and hang guard
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_width;
    t_waits;
    t_special;
    t_standby;
    complete_run;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run;
    end
  end
endmodule // external_area_bus_config_tb
`default_nettype wire
